// File: dv/tb_vpiu_top.sv
// self-checking bench for vpiu_top with a processor model
// assumes the package, design, model and checker compile first
`timescale 1ns/1ps
module tb_vpiu_top;
  import vpiu_pkg::*;
  logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, cpu_en, irq, vld, intr, inta;
  logic [ADR_W-1:0] wb_adr;
  logic [3:0] wb_sel, dly;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [7:0] req, taken;
  logic [15:0] vec, entry;
  int fail_count, cmp_count;

  vpiu_top DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .req_i(req), .inta_i(inta), .irq_o(irq),
    .vector_o(vec), .vector_valid_o(vld), .int_o(intr));
  vpiu_cpu_model u_cpu (.clk_i(clk), .rst_i(rst), .en_i(cpu_en),
    .dly_i(dly), .irq_i(irq), .vector_i(vec), .vector_valid_i(vld),
    .inta_o(inta), .entry_o(entry), .taken_o(taken));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    $display("MISMATCH %0t wait ran out", $time);
    finish_test();
  endtask
  // one classic cycle; read data lands in rd
  task automatic bus(input logic w, input logic [ADR_W-1:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
      if (n > 20) timeout();
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic init(input logic [15:0] base, input logic sp4);
    bus(1'b1, ADDR_PORT_A, {base[7:5], 2'b10, sp4, 2'b00});
    bus(1'b1, ADDR_PORT_B, base[15:8]);
  endtask
  task automatic eos();
    bus(1'b1, ADDR_PORT_A, 8'h20);
  endtask
  // wait for the model to finish one acknowledge, then judge the entry
  task automatic serve(input logic [15:0] exp);
    logic [7:0] t0;
    int n;
    t0 = taken;
    n = 0;
    while (taken === t0) begin
      @(posedge clk);
      n++;
      if (n > 40) timeout();
    end
    check({16'h0, entry}, {16'h0, exp});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    bus(1'b0, ADDR_PORT_B, 8'h00);
    check(rd, 32'h0);
    bus(1'b1, ADDR_PORT_A, 8'h0b);
    bus(1'b0, ADDR_PORT_A, 8'h00);
    check(rd, 32'h0);
    bus(1'b0, 5'h14, 8'h00);
    check(rd, 32'h0);
  endtask
  task automatic t_nested();
    init(16'h1200, 1'b0);
    req <= 8'h28;
    serve(16'h1218);
    repeat (5) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, ADDR_PORT_A, 8'h00);
    check(rd, 32'h08);
    req <= 8'h20;
    eos();
    serve(16'h1228);
    req <= 8'h28;
    serve(16'h1218);
    req <= 8'h00;
    eos();
    eos();
  endtask
  task automatic t_mask();
    dly <= 4'h5;
    init(16'habe0, 1'b1);
    req <= 8'h04;
    serve(16'habe8);
    req <= 8'h00;
    eos();
    cpu_en <= 1'b0;
    bus(1'b1, ADDR_PORT_B, 8'hff);
    req <= 8'hff;
    repeat (4) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, ADDR_PORT_B, 8'h00);
    check(rd, 32'hff);
    cpu_en <= 1'b1;
    bus(1'b1, ADDR_PORT_B, 8'h7f);
    serve(16'habfc);
    req <= 8'h00;
    eos();
    bus(1'b1, ADDR_PORT_B, 8'h00);
  endtask
  task automatic t_modes();
    bus(1'b1, ADDR_PORT_A, 8'ha8);
    req <= 8'h03;
    serve(16'habe0);
    eos();
    serve(16'habe4);
    eos();
    serve(16'habe0);
    req <= 8'h00;
    eos();
    bus(1'b1, ADDR_PORT_A, 8'hc8);
    bus(1'b1, ADDR_PORT_A, 8'hc3);
    req <= 8'h24;
    serve(16'habf4);
    req <= 8'h00;
    eos();
    bus(1'b1, ADDR_PORT_A, 8'he8);
    req <= 8'h50;
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, ADDR_PORT_A, 8'h00);
    check(rd, 32'h84);
    req <= 8'h00;
  endtask
  task automatic t_events();
    init(16'h4000, 1'b0);
    bus(1'b1, ADDR_EV_CLEAR, 8'h07);
    bus(1'b1, ADDR_EV_ENABLE, 8'h01);
    req <= 8'h01;
    serve(16'h4000);
    req <= 8'h00;
    repeat (2) @(posedge clk);
    check({31'h0, intr}, 32'h1);
    bus(1'b0, ADDR_EV_STATUS, 8'h00);
    check(rd, 32'h1);
    bus(1'b1, ADDR_EV_ENABLE, 8'h00);
    repeat (2) @(posedge clk);
    check({31'h0, intr}, 32'h0);
    bus(1'b1, ADDR_EV_ENABLE, 8'h01);
    bus(1'b1, ADDR_EV_CLEAR, 8'h01);
    repeat (2) @(posedge clk);
    check({31'h0, intr}, 32'h0);
    bus(1'b0, ADDR_EV_STATUS, 8'h00);
    check(rd, 32'h0);
  endtask
  // mid-run reset: level 0 is still in service and the mask is set
  task automatic t_rerun();
    bus(1'b1, ADDR_PORT_B, 8'h0f);
    bus(1'b0, ADDR_PORT_A, 8'h00);
    check(rd, 32'h01);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check({16'h0, vec}, 32'h0);
    bus(1'b0, ADDR_PORT_B, 8'h00);
    check(rd, 32'h0);
    bus(1'b1, ADDR_PORT_A, 8'h0b);
    bus(1'b0, ADDR_PORT_A, 8'h00);
    check(rd, 32'h0);
  endtask
  // rotate on/off, end-of-service variants and the one-shot poll
  task automatic t_cmds();
    bus(1'b1, ADDR_PORT_A, 8'h80);
    req <= 8'h06;
    serve(16'h0008);
    bus(1'b1, ADDR_PORT_A, 8'ha0);
    serve(16'h0010);
    bus(1'b1, ADDR_PORT_A, 8'he2);
    serve(16'h0008);
    req <= 8'h00;
    bus(1'b1, ADDR_PORT_A, 8'h00);
    bus(1'b1, ADDR_PORT_A, 8'h61);
    req <= 8'h84;
    serve(16'h0010);
    cpu_en <= 1'b0;
    req <= 8'h10;
    eos();
    bus(1'b1, ADDR_PORT_A, 8'h0c);
    bus(1'b0, ADDR_PORT_A, 8'h00);
    check(rd, 32'h84);
    bus(1'b0, ADDR_PORT_A, 8'h00);
    check(rd, 32'h10);
    cpu_en <= 1'b1;
    req <= 8'h00;
  endtask

  // ==========================================================
  // clock, reset and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    fail_count = 0;
    cmp_count = 0;
    rst <= 1'b1;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_adr <= '0;
    wb_sel <= 4'hf;
    wb_wdat <= 32'h0;
    req <= 8'h00;
    cpu_en <= 1'b1;
    dly <= 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_nested();
    t_mask();
    t_modes();
    t_events();
    t_rerun();
    t_cmds();
    finish_test();
  end
endmodule // tb_vpiu_top

// File: dv/vpiu_cpu_model.sv
// processor model: answers irq with a one-cycle acknowledge pulse
// assumes the unit strobes its vector one cycle after the pulse
`timescale 1ns/1ps
module vpiu_cpu_model (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic en_i, // answer interrupts
  input wire logic [3:0] dly_i, // cycles before acknowledge
  input wire logic irq_i, // interrupt from unit
  input wire logic [15:0] vector_i, // vector address
  input wire logic vector_valid_i, // vector strobe
  output logic inta_o, // acknowledge pulse
  output logic [15:0] entry_o, // last jump entry
  output logic [7:0] taken_o // completed acknowledges
);
  logic [3:0] wait_cnt;
  logic busy;
  // ==========================================================
  // one pulse per interrupt; busy stops a second pulse before the
  // unit has dropped irq
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inta_o <= 1'b0;
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      entry_o <= 16'h0000;
      taken_o <= 8'h00;
    end else begin
      inta_o <= 1'b0;
      if (en_i && irq_i && !busy) begin
        if (wait_cnt == dly_i) begin
          inta_o <= 1'b1;
          busy <= 1'b1;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
      if (vector_valid_i) begin
        busy <= 1'b0;
        entry_o <= vector_i;
        taken_o <= taken_o + 8'h01;
      end
    end
  end
endmodule // vpiu_cpu_model

// File: dv/vpiu_top_sva.sv
// port checker for the vectored priority interrupt unit
// assumes it is bound to vpiu_top with a single clock domain
`timescale 1ns/1ps
module vpiu_top_sva
  import vpiu_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [vpiu_pkg::ADR_W-1:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic [vpiu_pkg::NUM_LEVELS-1:0] req_i, // requests
  input wire logic inta_i, // processor acknowledge
  input wire logic irq_o, // interrupt
  input wire logic [15:0] vector_o, // vector
  input wire logic vector_valid_o, // vector strobe
  input wire logic int_o // event interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // bus and vector timing
  AST_ACK_WAIT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_VALID: assert property (
    inta_i |=> vector_valid_o ##1 !vector_valid_o)
    else $error("vector strobe not a pulse after acknowledge");
  AST_VALID_CAUSE: assert property (vector_valid_o |-> $past(inta_i))
    else $error("vector strobe without acknowledge");
  AST_VEC_HOLD: assert property (!inta_i |=> $stable(vector_o))
    else $error("vector changed without acknowledge");
  AST_VEC_ALIGN: assert property (
    vector_valid_o |-> vector_o[1:0] == 2'h0)
    else $error("vector not on a 4 byte step");
  // ==========================================================
  // interrupt request behaviour
  AST_SERVE_DROP: assert property (inta_i && irq_o |=> !irq_o)
    else $error("irq still high after service began");
  AST_IRQ_CAUSE: assert property (irq_o |-> $past(|req_i))
    else $error("irq without a pending request");
  // irq is dropped at the acknowledge edge, so it must be low with the vector
  AST_VALID_IRQ_LOW: assert property (vector_valid_o |-> !irq_o)
    else $error("irq still high while the vector is strobed");
  cover property (vector_valid_o);
  cover property ($rose(int_o));
  cover property (irq_o ##1 !irq_o);
endmodule // vpiu_top_sva

bind vpiu_top vpiu_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i),
  .inta_i(inta_i), .irq_o(irq_o), .vector_o(vector_o),
  .vector_valid_o(vector_valid_o), .int_o(int_o));

// File: hdl/vpiu_pkg.sv
// constants, encodings and offsets of the vectored priority interrupt unit
// assumes a classic wishbone master with 32-bit data, byte-addressed
package vpiu_pkg;
  // ==========================================================
  // geometry
  localparam int NUM_LEVELS = 8;
  localparam int LVL_W = 3;
  localparam int ADR_W = 5;
  localparam int EV_W = 3;

  // ==========================================================
  // register byte offsets
  localparam logic [ADR_W-1:0] ADDR_PORT_A = 5'h00;
  localparam logic [ADR_W-1:0] ADDR_PORT_B = 5'h04;
  localparam logic [ADR_W-1:0] ADDR_EV_STATUS = 5'h08;
  localparam logic [ADR_W-1:0] ADDR_EV_CLEAR = 5'h0c;
  localparam logic [ADR_W-1:0] ADDR_EV_ENABLE = 5'h10;

  // ==========================================================
  // control word fields
  localparam int INIT_SEL_BIT = 4;
  localparam int INIT_SPACE4_BIT = 2;
  localparam int INIT_BASE_LSB = 5;
  localparam int OP3_SEL_BIT = 3;
  localparam int OP3_POLL_BIT = 2;
  localparam int OP3_MODE_EN_BIT = 7;
  localparam int OP3_MODE_LSB = 5;
  localparam int CMD_LSB = 5;
  localparam int POLL_VALID_BIT = 7;
  localparam logic [1:0] RDSEL_REQ = 2'h2;
  localparam logic [1:0] RDSEL_ISR = 2'h3;

  // end-of-service and priority commands
  localparam logic [2:0] CMD_ROT_OFF = 3'h0;
  localparam logic [2:0] CMD_EOS = 3'h1;
  localparam logic [2:0] CMD_NOP = 3'h2;
  localparam logic [2:0] CMD_EOS_SPEC = 3'h3;
  localparam logic [2:0] CMD_ROT_ON = 3'h4;
  localparam logic [2:0] CMD_EOS_ROT = 3'h5;
  localparam logic [2:0] CMD_SET_PRIO = 3'h6;
  localparam logic [2:0] CMD_EOS_SPEC_ROT = 3'h7;

  // event bits
  localparam int EV_GRANT = 0;
  localparam int EV_SPURIOUS = 1;
  localparam int EV_POLL = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [LVL_W-1:0] LOWEST_RST = 3'h7;
  localparam logic [LVL_W-1:0] LOWEST_FIXED = 3'h7;

  typedef enum logic [1:0] {
    MODE_NESTED,
    MODE_ROTATE,
    MODE_SPECIFIC,
    MODE_POLLED
  } vpiu_mode_e;
endpackage

// File: hdl/vpiu_prio_pick.sv
// circular priority picker: finds the best-ranked set bit of a vector
// assumes lowest_i names the level of least priority
`timescale 1ns/1ps
module vpiu_prio_pick
  import vpiu_pkg::*;
(
  input wire logic [NUM_LEVELS-1:0] vec_i, // candidate levels
  input wire logic [LVL_W-1:0] lowest_i, // lowest-priority level
  output logic any_o, // some bit set
  output logic [LVL_W-1:0] level_o, // winning level
  output logic [LVL_W-1:0] rank_o // winner rank, 0 is best
);
  logic [LVL_W-1:0] idx;

  // ==========================================================
  // scan from worst rank to best so the best hit is kept last
  always_comb begin
    any_o = 1'b0;
    level_o = '0;
    rank_o = LOWEST_FIXED;
    idx = '0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      idx = LVL_W'(lowest_i + 3'h1 + LVL_W'(i));
      if (vec_i[idx]) begin
        any_o = 1'b1;
        level_o = idx;
        rank_o = LVL_W'(i);
      end
    end
  end
endmodule // vpiu_prio_pick

// File: hdl/vpiu_top.sv
// vectored priority interrupt unit with a classic wishbone slave
// assumes level requests synchronous to clk_i and a one-cycle
// processor acknowledge pulse on inta_i
`timescale 1ns/1ps
module vpiu_top
  import vpiu_pkg::*;
(
  input wire logic clk_i, // 250 mhz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [vpiu_pkg::ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic [vpiu_pkg::NUM_LEVELS-1:0] req_i, // request lines
  input wire logic inta_i, // processor acknowledge pulse
  output logic irq_o, // interrupt to processor
  output logic [15:0] vector_o, // vector address
  output logic vector_valid_o, // vector strobe
  output logic int_o // event interrupt
);
  // ==========================================================
  // state
  logic [NUM_LEVELS-1:0] mask;
  logic [NUM_LEVELS-1:0] isr;
  logic [15:0] base;
  logic space4;
  logic base_pending;
  vpiu_mode_e mode;
  logic [LVL_W-1:0] lowest;
  logic [1:0] rd_sel;
  logic poll_once;
  logic [EV_W-1:0] ev_status;
  logic [EV_W-1:0] ev_enable;

  // ==========================================================
  // bus decode
  logic acc;
  logic wr_fire;
  logic rd_fire;
  logic byte0;
  logic [7:0] wd;

  assign acc = wb_cyc_i & wb_stb_i;
  // writes act at the edge where the master samples ack
  assign wr_fire = acc & wb_we_i & wb_ack_o & wb_sel_i[0];
  // read side effects fire once, as ack is raised
  assign rd_fire = acc & ~wb_we_i & ~wb_ack_o;
  assign byte0 = wb_sel_i[0];
  assign wd = wb_dat_i[7:0];

  logic wr_a;
  logic wr_b;
  logic is_init;
  logic is_op3;
  logic is_op2;
  logic [2:0] cmd;
  logic [LVL_W-1:0] cmd_lvl;

  assign wr_a = wr_fire && (wb_adr_i == ADDR_PORT_A);
  assign wr_b = wr_fire && (wb_adr_i == ADDR_PORT_B);
  // one bit of the word written picks init or operation words
  assign is_init = wr_a & wd[INIT_SEL_BIT];
  assign is_op3 = wr_a & ~wd[INIT_SEL_BIT] & wd[OP3_SEL_BIT];
  assign is_op2 = wr_a & ~wd[INIT_SEL_BIT] & ~wd[OP3_SEL_BIT];
  assign cmd = wd[CMD_LSB +: 3];
  assign cmd_lvl = wd[LVL_W-1:0];

  // ==========================================================
  // priority resolution
  logic [LVL_W-1:0] eff_lowest;
  logic [NUM_LEVELS-1:0] pending;
  logic req_any;
  logic [LVL_W-1:0] req_lvl;
  logic [LVL_W-1:0] req_rank;
  logic isr_any;
  logic [LVL_W-1:0] isr_lvl;
  logic [LVL_W-1:0] isr_rank;
  logic want;

  always_comb begin
    case (mode)
      MODE_NESTED: eff_lowest = LOWEST_FIXED;
      MODE_POLLED: eff_lowest = LOWEST_FIXED;
      MODE_ROTATE: eff_lowest = lowest;
      MODE_SPECIFIC: eff_lowest = lowest;
      default: eff_lowest = LOWEST_FIXED;
    endcase
  end

  // levels already in service do not request again
  assign pending = req_i & ~mask & ~isr;

  vpiu_prio_pick u_req_pick (
    .vec_i(pending),
    .lowest_i(eff_lowest),
    .any_o(req_any),
    .level_o(req_lvl),
    .rank_o(req_rank)
  );

  vpiu_prio_pick u_isr_pick (
    .vec_i(isr),
    .lowest_i(eff_lowest),
    .any_o(isr_any),
    .level_o(isr_lvl),
    .rank_o(isr_rank)
  );

  // equal or lower ranks wait for the level in service
  assign want = req_any && (!isr_any || req_rank < isr_rank);

  // ==========================================================
  // vector address
  logic [15:0] vec_addr;
  logic [LVL_W-1:0] ack_lvl;

  // a vanished request at acknowledge gets the worst-ranked vector
  assign ack_lvl = want ? req_lvl : eff_lowest;

  vpiu_vec_gen u_vec (
    .base_i(base),
    .space4_i(space4),
    .level_i(ack_lvl),
    .addr_o(vec_addr)
  );

  // ==========================================================
  // poll word and port reads
  logic [7:0] poll_word;
  logic poll_read;
  logic [7:0] port_a_rd;

  assign poll_word = {want, 4'h0, req_lvl} & {1'b1, 4'h0, {LVL_W{want}}};
  assign poll_read = rd_fire && (wb_adr_i == ADDR_PORT_A) &&
                     (mode == MODE_POLLED || poll_once);

  always_comb begin
    if (mode == MODE_POLLED || poll_once) begin
      port_a_rd = poll_word;
    end else if (rd_sel == RDSEL_ISR) begin
      port_a_rd = isr;
    end else begin
      port_a_rd = req_i;
    end
  end

  // ==========================================================
  // mask and table base
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= MASK_RST;
    end else if (wr_b && !base_pending) begin
      mask <= wd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base <= BASE_RST;
      space4 <= 1'b0;
      base_pending <= 1'b0;
    end else if (is_init) begin
      base[7:5] <= wd[INIT_BASE_LSB +: 3];
      space4 <= wd[INIT_SPACE4_BIT];
      base_pending <= 1'b1;
    end else if (wr_b && base_pending) begin
      base[15:8] <= wd;
      base_pending <= 1'b0;
    end
  end

  // ==========================================================
  // mode, lowest level and read select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= MODE_NESTED;
    end else if (is_init) begin
      mode <= MODE_NESTED;
    end else if (is_op3 && wd[OP3_MODE_EN_BIT]) begin
      mode <= vpiu_mode_e'(wd[OP3_MODE_LSB +: 2]);
    end else if (is_op2 && cmd == CMD_ROT_ON) begin
      mode <= MODE_ROTATE;
    end else if (is_op2 && cmd == CMD_ROT_OFF) begin
      mode <= MODE_NESTED;
    end else if (is_op2 && cmd == CMD_SET_PRIO) begin
      mode <= MODE_SPECIFIC;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lowest <= LOWEST_RST;
    end else if (is_op2) begin
      case (cmd)
        CMD_SET_PRIO: lowest <= cmd_lvl;
        CMD_EOS_SPEC_ROT: lowest <= cmd_lvl;
        CMD_EOS_ROT: begin
          if (isr_any) begin
            lowest <= isr_lvl;
          end
        end
        CMD_EOS: begin
          if (isr_any && mode == MODE_ROTATE) begin
            lowest <= isr_lvl;
          end
        end
        default: lowest <= lowest;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_sel <= RDSEL_REQ;
      poll_once <= 1'b0;
    end else if (is_op3) begin
      if (wd[1]) begin
        rd_sel <= wd[1:0];
      end
      poll_once <= wd[OP3_POLL_BIT];
    end else if (poll_read) begin
      poll_once <= 1'b0;
    end
  end

  // ==========================================================
  // in-service set
  logic [NUM_LEVELS-1:0] isr_set;
  logic [NUM_LEVELS-1:0] isr_clr;

  always_comb begin
    isr_set = '0;
    isr_clr = '0;
    if ((inta_i && mode != MODE_POLLED && want) ||
        (poll_read && want)) begin
      isr_set[req_lvl] = 1'b1;
    end
    if (is_init) begin
      isr_clr = '1;
    end else if (is_op2) begin
      case (cmd)
        CMD_EOS: isr_clr[isr_lvl] = isr_any;
        CMD_EOS_ROT: isr_clr[isr_lvl] = isr_any;
        CMD_EOS_SPEC: isr_clr[cmd_lvl] = 1'b1;
        CMD_EOS_SPEC_ROT: isr_clr[cmd_lvl] = 1'b1;
        default: isr_clr = '0;
      endcase
    end
  end

  // a grant in the same cycle as a clear keeps its bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isr <= '0;
    end else begin
      isr <= (isr & ~isr_clr) | isr_set;
    end
  end

  // ==========================================================
  // processor side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      // dropped on acknowledge so one request gives one interrupt
      irq_o <= want && mode != MODE_POLLED && !inta_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_o <= '0;
      vector_valid_o <= 1'b0;
    end else begin
      vector_valid_o <= inta_i;
      if (inta_i) begin
        vector_o <= vec_addr;
      end
    end
  end

  // ==========================================================
  // event status, enable and clear
  logic [EV_W-1:0] ev_hit;
  logic [EV_W-1:0] ev_clr;

  always_comb begin
    ev_hit = '0;
    ev_hit[EV_GRANT] = inta_i & want & (mode != MODE_POLLED);
    ev_hit[EV_SPURIOUS] = inta_i & ~want;
    ev_hit[EV_POLL] = poll_read & want;
  end

  assign ev_clr = (wr_fire && wb_adr_i == ADDR_EV_CLEAR) ?
                  wd[EV_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_status <= '0;
    end else begin
      ev_status <= (ev_status & ~ev_clr) | ev_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_enable <= '0;
    end else if (wr_fire && wb_adr_i == ADDR_EV_ENABLE) begin
      ev_enable <= wd[EV_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_o <= 1'b0;
    end else begin
      int_o <= |(ev_status & ev_enable);
    end
  end

  // ==========================================================
  // wishbone answer: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd_fire) begin
      wb_dat_o <= '0;
      if (byte0) begin
        case (wb_adr_i)
          ADDR_PORT_A: wb_dat_o <= {24'h0, port_a_rd};
          ADDR_PORT_B: wb_dat_o <= {24'h0, mask};
          ADDR_EV_STATUS: wb_dat_o <= {29'h0, ev_status};
          ADDR_EV_ENABLE: wb_dat_o <= {29'h0, ev_enable};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule // vpiu_top

// File: hdl/vpiu_vec_gen.sv
// vector address generator: table base plus level times spacing
// assumes the base is kept aligned to the table size by the caller
`timescale 1ns/1ps
module vpiu_vec_gen
  import vpiu_pkg::*;
(
  input wire logic [15:0] base_i, // table base address
  input wire logic space4_i, // 1: 4-byte spacing, 0: 8-byte
  input wire logic [LVL_W-1:0] level_i, // level to vector
  output logic [15:0] addr_o // entry address
);
  // ==========================================================
  // low base bits under the level field are ignored on purpose
  always_comb begin
    if (space4_i) begin
      addr_o = {base_i[15:5], level_i, 2'b00};
    end else begin
      addr_o = {base_i[15:6], level_i, 3'b000};
    end
  end
endmodule // vpiu_vec_gen
